//--- core/adc_cal_bw_powerdown_regs.sv
// calibration, init-key, bandwidth and channel power-down register bank
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module adc_cal_bw_powerdown_regs
(
    input  wire logic                           clock,
    input  wire logic                           srst,
    input  wire logic [adc_cfg_pkg::ADDR_W-1:0] addr,
    input  wire logic [adc_cfg_pkg::DATA_W-1:0] wrData,
    input  wire logic                           wrStrobe,
    input  wire logic                           rdStrobe,
    output logic      [adc_cfg_pkg::DATA_W-1:0] rdData,
    output logic                                gainCalEnable,
    output logic                                initSeqOpen,
    output logic                                initDone,
    output logic                                bwWideA,
    output logic                                bwWideB,
    output logic                                powerDownA,
    output logic                                powerDownB
);
    import adc_cfg_pkg::*;

    reg_store_if rs ();

    reg_store u_store (
        .clock (clock),
        .srst  (srst),
        .port  (rs.store)
    );

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic       hit;
    logic [1:0] idx;

    always_comb
    begin
        hit = 1'b1;
        idx = IDX_33;
        if (addr == OFFS_GAIN_CAL_INIT_KEY_CTRL)
            idx = IDX_33;
        else if (addr == OFFS_GAIN_CAL_CTRL_EXTRA)
            idx = IDX_34;
        else if (addr == OFFS_INIT_DONE_CTRL)
            idx = IDX_37;
        else if (addr == OFFS_BANDWIDTH_POWERDOWN_CTRL)
            idx = IDX_C0;
        else
            hit = 1'b0;
    end

    // all bits are stored as written; reserved bits are the writer's care
    assign rs.wrEn   = wrStrobe && hit;
    assign rs.wrIdx  = idx;
    assign rs.wrData = wrData;

    // ------------------------------------------------------------
    // named fields of the stored words
    // ------------------------------------------------------------
    logic       gainCalEnableC;
    logic       gainCalEnableB;
    logic       gainCalEnableD;
    logic [1:0] initSequenceKey;
    logic [2:0] initDoneField;
    logic       bandwidthSelectB;
    logic       bandwidthSelectA;
    logic [1:0] channelPowerdown;

    assign gainCalEnableC   = rs.regs[IDX_33][GAIN_CAL_C_BIT];
    assign gainCalEnableB   = rs.regs[IDX_33][GAIN_CAL_B_BIT];
    assign gainCalEnableD   = rs.regs[IDX_34][GAIN_CAL_D_BIT];
    assign initSequenceKey  = rs.regs[IDX_33][INIT_KEY_HI:INIT_KEY_LO];
    assign initDoneField    = rs.regs[IDX_37][INIT_DONE_HI:INIT_DONE_LO];
    assign bandwidthSelectB = rs.regs[IDX_C0][BW_B_BIT];
    assign bandwidthSelectA = rs.regs[IDX_C0][BW_A_BIT];
    assign channelPowerdown = rs.regs[IDX_C0][PD_HI:PD_LO];

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [DATA_W-1:0] next_rdData;

    // unmapped reads answer zero, and the port idles at zero
    always_comb
    begin
        next_rdData = REG_RESET;
        if (srst)
            next_rdData = REG_RESET;
        else if (rdStrobe && hit)
            next_rdData = rs.regs[idx];
    end

    always_ff @(posedge clock)
    begin
        rdData <= next_rdData;
    end

    // ------------------------------------------------------------
    // gain calibration enable
    // ------------------------------------------------------------
    logic next_gainCalEnable;

    // any of the three global enables turns calibration on
    always_comb
    begin
        next_gainCalEnable = 1'b0;
        if (srst)
            next_gainCalEnable = 1'b0;
        else
            next_gainCalEnable = gainCalEnableC | gainCalEnableB | gainCalEnableD;
    end

    always_ff @(posedge clock)
    begin
        gainCalEnable <= next_gainCalEnable;
    end

    // ------------------------------------------------------------
    // initialization key and done code
    // ------------------------------------------------------------
    logic next_initSeqOpen;
    logic next_initDone;

    // only the exact codes count; any other value leaves the flag low
    always_comb
    begin
        next_initSeqOpen = 1'b0;
        next_initDone    = 1'b0;
        if (srst)
        begin
            next_initSeqOpen = 1'b0;
            next_initDone    = 1'b0;
        end
        else
        begin
            next_initSeqOpen = (initSequenceKey == INIT_KEY_OPEN);
            next_initDone    = (initDoneField == INIT_DONE_CODE);
        end
    end

    always_ff @(posedge clock)
    begin
        initSeqOpen <= next_initSeqOpen;
        initDone    <= next_initDone;
    end

    // ------------------------------------------------------------
    // analog bandwidth selection
    // ------------------------------------------------------------
    logic next_bwWideA;
    logic next_bwWideB;

    // controls follow the stored words, so they lag a write by two cycles
    always_comb
    begin
        next_bwWideA = 1'b0;
        next_bwWideB = 1'b0;
        if (srst)
        begin
            next_bwWideA = 1'b0;
            next_bwWideB = 1'b0;
        end
        else
        begin
            next_bwWideB = bandwidthSelectB;
            next_bwWideA = bandwidthSelectA;
        end
    end

    always_ff @(posedge clock)
    begin
        bwWideA <= next_bwWideA;
        bwWideB <= next_bwWideB;
    end

    // ------------------------------------------------------------
    // channel power-down
    // ------------------------------------------------------------
    logic       next_powerDownA;
    logic       next_powerDownB;
    powerdown_t pdSel;

    always_comb
    begin
        pdSel           = powerdown_t'(channelPowerdown);
        next_powerDownA = 1'b0;
        next_powerDownB = 1'b0;
        if (srst)
        begin
            next_powerDownA = 1'b0;
            next_powerDownB = 1'b0;
        end
        else
        begin
            case (pdSel)
                PD_NONE:
                begin
                    next_powerDownA = 1'b0;
                    next_powerDownB = 1'b0;
                end
                PD_CHAN_B:
                begin
                    next_powerDownA = 1'b0;
                    next_powerDownB = 1'b1;
                end
                PD_CHAN_A:
                begin
                    next_powerDownA = 1'b1;
                    next_powerDownB = 1'b0;
                end
                PD_BOTH:
                begin
                    next_powerDownA = 1'b1;
                    next_powerDownB = 1'b1;
                end
                default:
                begin
                    next_powerDownA = 1'b0;
                    next_powerDownB = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        powerDownA <= next_powerDownA;
        powerDownB <= next_powerDownB;
    end
endmodule : adc_cal_bw_powerdown_regs

//--- core/adc_cfg_pkg.sv
// constants for the calibration, bandwidth and power-down register bank
package adc_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    localparam logic [7:0] OFFS_GAIN_CAL_INIT_KEY_CTRL   = 8'h33;
    localparam logic [7:0] OFFS_GAIN_CAL_CTRL_EXTRA      = 8'h34;
    localparam logic [7:0] OFFS_INIT_DONE_CTRL           = 8'h37;
    localparam logic [7:0] OFFS_BANDWIDTH_POWERDOWN_CTRL = 8'hC0;

    localparam logic [15:0] REG_RESET = 16'h0000;

    localparam int GAIN_CAL_C_BIT  = 13;
    localparam int GAIN_CAL_B_BIT  = 6;
    localparam int INIT_KEY_HI     = 5;
    localparam int INIT_KEY_LO     = 4;
    localparam int GAIN_CAL_D_BIT  = 4;
    localparam int INIT_DONE_HI    = 2;
    localparam int INIT_DONE_LO    = 0;
    localparam int BW_B_BIT        = 7;
    localparam int BW_A_BIT        = 4;
    localparam int PD_HI           = 1;
    localparam int PD_LO           = 0;

    localparam logic [1:0] INIT_KEY_OPEN   = 2'h3;
    localparam logic [1:0] INIT_KEY_NORMAL = 2'h0;
    localparam logic [2:0] INIT_DONE_CODE  = 3'h5;

    localparam int NUM_REGS = 4;
    localparam logic [1:0] IDX_33 = 2'h0;
    localparam logic [1:0] IDX_34 = 2'h1;
    localparam logic [1:0] IDX_37 = 2'h2;
    localparam logic [1:0] IDX_C0 = 2'h3;

    typedef enum logic [1:0] {
        PD_NONE,
        PD_CHAN_B,
        PD_CHAN_A,
        PD_BOTH
    } powerdown_t;
endpackage : adc_cfg_pkg

//--- core/reg_store_if.sv
// interface between the bank decoder and its register store
`timescale 1ns/10ps
interface reg_store_if;
    import adc_cfg_pkg::*;
    logic              wrEn;
    logic [1:0]        wrIdx;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] regs [NUM_REGS];

    modport ctrl  (output wrEn, output wrIdx, output wrData, input regs);
    modport store (input wrEn, input wrIdx, input wrData, output regs);
endinterface : reg_store_if

//--- core/reg_store.sv
// register store: one word per entry, synchronous clear
`timescale 1ns/10ps
module reg_store
(
    input wire logic   clock,
    input wire logic   srst,
    reg_store_if.store port
);
    import adc_cfg_pkg::*;

    logic [DATA_W-1:0] word      [NUM_REGS];
    logic [DATA_W-1:0] next_word [NUM_REGS];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++)
        begin : g_entry
            always_comb
            begin
                next_word[gi] = word[gi];
                if (srst)
                    next_word[gi] = REG_RESET;
                else if (port.wrEn && port.wrIdx == 2'(gi))
                    next_word[gi] = port.wrData;
            end

            always_ff @(posedge clock)
            begin
                word[gi] <= next_word[gi];
            end

            assign port.regs[gi] = word[gi];
        end
    endgenerate
endmodule : reg_store

//--- verification/adc_cal_bw_powerdown_regs_checker.sv
// port assertions for the register bank
`timescale 1ns/10ps
module adc_cal_bw_powerdown_regs_checker (
    input wire logic        clock,
    input wire logic        srst,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wrData,
    input wire logic        wrStrobe,
    input wire logic        rdStrobe,
    input wire logic [15:0] rdData,
    input wire logic        gainCalEnable,
    input wire logic        initSeqOpen,
    input wire logic        initDone,
    input wire logic        bwWideA,
    input wire logic        bwWideB,
    input wire logic        powerDownA,
    input wire logic        powerDownB
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (srst);
    wire logic wC0 = wrStrobe && addr == 8'hC0;
    wire logic w33 = wrStrobe && addr == 8'h33;
    AST_BW_B: assert property (wC0 |-> ##2 bwWideB == $past(wrData[7], 2))
        else $error("bandwidth B");
    AST_BW_A: assert property (wC0 |-> ##2 bwWideA == $past(wrData[4], 2))
        else $error("bandwidth A");
    AST_PD: assert property (wC0 |-> ##2 {powerDownA, powerDownB} == $past(wrData[1:0], 2))
        else $error("power down");
    AST_GAIN: assert property ((w33 && (wrData[13] || wrData[6])) ||
        (wrStrobe && addr == 8'h34 && wrData[4]) |-> ##2 gainCalEnable) else $error("gain cal");
    AST_KEY: assert property (w33 |-> ##2 initSeqOpen == ($past(wrData[5:4], 2) == 2'h3))
        else $error("init key");
    AST_DONE: assert property (wrStrobe && addr == 8'h37 |-> ##2
        initDone == ($past(wrData[2:0], 2) == 3'h5)) else $error("init done");
    AST_RESET: assert property ($fell(srst) |-> rdData == 16'h0000 && !gainCalEnable &&
        !initSeqOpen && !initDone && !bwWideA && !bwWideB && !powerDownA && !powerDownB)
        else $error("reset");
    AST_IDLE: assert property (!rdStrobe |=> rdData == 16'h0000)
        else $error("read data idle");
    AST_READ: assert property (wC0 ##1 (rdStrobe && addr == 8'hC0) |=>
        rdData == $past(wrData, 2)) else $error("read back");
    cover property (wC0 ##1 rdStrobe);
    cover property (initSeqOpen);
    cover property (powerDownA && powerDownB);
endmodule : adc_cal_bw_powerdown_regs_checker

bind adc_cal_bw_powerdown_regs adc_cal_bw_powerdown_regs_checker chk (.clock(clock),
    .srst(srst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .gainCalEnable(gainCalEnable), .initSeqOpen(initSeqOpen),
    .initDone(initDone),
    .bwWideA(bwWideA), .bwWideB(bwWideB), .powerDownA(powerDownA), .powerDownB(powerDownB));

//--- verification/testbench.sv
// self-checking bench for the register bank
`timescale 1ns/10ps
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
    logic        clock = 1'b0, srst = 1'b1, wrStrobe = 1'b0, rdStrobe = 1'b0, rdPend = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wrData = 16'h0000, rdData, x;
    logic [15:0] e [logic [7:0]];
    logic [15:0] q [$];
    logic        gce, iso, idn, bwA, bwB, pdA, pdB;
    int          failures = 0, samplesChecked = 0, cycles = 0, n;
    logic [7:0]  ta [16] = '{8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'h33,
                            8'h33, 8'h33, 8'h33, 8'h34, 8'h34, 8'h37, 8'h37, 8'h35};
    logic [15:0] td [16] = '{16'h0093, 16'h0080, 16'h0010, 16'h0001, 16'h0002, 16'h0003,
        16'h0000, 16'h2000, 16'h0040, 16'h0030, 16'h0000, 16'h0010, 16'h0000, 16'h0005,
        16'h0004, 16'hFFFF};
    logic [7:0]  ra [4] = '{8'h33, 8'h34, 8'h37, 8'hC0};
    logic [15:0] rm [4] = '{16'h2070, 16'h0010, 16'h0007, 16'h0093};
    adc_cal_bw_powerdown_regs dut (.clock(clock), .srst(srst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .gainCalEnable(gce),
        .initSeqOpen(iso), .initDone(idn), .bwWideA(bwA), .bwWideB(bwB), .powerDownA(pdA),
        .powerDownB(pdB));
    always #20 clock = ~clock;
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        rdStrobe <= 1'b0;
        if (e.exists(a)) e[a] = d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b1;
        q.push_back(e.exists(a) ? e[a] : 16'h0000);
    endtask : rd
    task automatic idle;
        @(posedge clock);
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b0;
    endtask : idle
    task automatic outs;
        logic [6:0] x7;
        idle;
        idle;
        #1;
        x7 = {e[8'h33][13] | e[8'h33][6] | e[8'h34][4], e[8'h33][5:4] == 2'h3,
            e[8'h37][2:0] == 3'h5, e[8'hC0][4], e[8'hC0][7], e[8'hC0][1:0]};
        `CHK("outputs", x7, {gce, iso, idn, bwA, bwB, pdA, pdB})
    endtask : outs
    task automatic rst;
        @(posedge clock);
        srst <= 1'b1;
        repeat (19) @(posedge clock);
        srst <= 1'b0;
        foreach (ra[i]) e[ra[i]] = 16'h0000;
    endtask : rst
    task automatic test_done;
        $display("failures %0d compares %0d", failures, samplesChecked);
        if (failures == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // read results land one cycle after the strobe
    always @(posedge clock)
    begin
        cycles++;
        if (rdPend)
        begin
            x = q.pop_front();
            `CHK("rdData", x, rdData)
        end
        rdPend <= rdStrobe;
        if (cycles == 1000)
        begin
            failures++;
            test_done;
        end
    end
    initial
    begin
        void'($urandom(28));
        rst;
        outs;
        foreach (ta[i])
        begin
            wr(ta[i], td[i]);
            rd(ta[i]);
            outs;
        end
        repeat (16)
        begin
            n = $urandom % 4;
            wr(ra[n], rm[n] & 16'($urandom));
            rd(ra[n]);
        end
        outs;
        rst;
        foreach (ra[i]) rd(ra[i]);
        outs;
        `CHK("pending reads", 0, q.size())
        test_done;
    end
endmodule : testbench
